// ### verilog/htc_timer.sv
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module htc_timer
    import htc_pkg::*;
#(
    parameter htc_ctrl_t        PRE_CTRL     = htc_pkg::CTRL_RST,
    parameter logic [15:0]      PRE_PRESCALE = htc_pkg::PRESCALE_RST,
    parameter logic [15:0]      PRE_TOP      = htc_pkg::TOP_RST,
    parameter logic [15:0]      PRE_COMPARE  = htc_pkg::COMPARE_RST,
    parameter logic [15:0]      PRE_RELOAD   = htc_pkg::RELOAD_RST,
    parameter logic [2:0]       PRE_IRQEN    = htc_pkg::IRQEN_RST
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire htc_pkg::htc_avs_req_t bus_req,
    output logic [htc_pkg::DATA_W-1:0] readdata,
    output logic                       waitrequest,
    input  wire logic                  register_bus_enable,
    input  wire logic                  timer_clock_in,
    input  wire logic                  timer_reset_in_n,
    input  wire logic                  capture_trigger_in,
    output logic                       compare_wave_out,
    output logic [htc_pkg::CNT_W-1:0]  count_value,
    output logic                       timer_irq_out,
    output logic                       wake_irq_out
);

    import htc_pkg::*;

    typedef struct packed {
        htc_ctrl_t         ctrl;
        logic [CNT_W-1:0]  prescale;
        logic [CNT_W-1:0]  top;
        logic [CNT_W-1:0]  cmp;
        logic [CNT_W-1:0]  reload;
        logic [CNT_W-1:0]  top_sh;
        logic [CNT_W-1:0]  cmp_sh;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  pre_cnt;
        logic [CNT_W-1:0]  cap;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   irqen;
        logic              going_down;
        logic              oc;
        logic              prev_trig;
        logic              prev_tclk;
        logic              cap_det;
        logic              wake;
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } htc_state_t;

    localparam htc_state_t STATE_RST = '{
        ctrl: PRE_CTRL, prescale: PRE_PRESCALE, top: PRE_TOP, cmp: PRE_COMPARE,
        reload: PRE_RELOAD, top_sh: PRE_TOP, cmp_sh: PRE_COMPARE, cnt: '0,
        pre_cnt: '0, cap: '0, status: '0, irqen: PRE_IRQEN, going_down: 1'b0,
        oc: 1'b0, prev_trig: 1'b0, prev_tclk: 1'b0, cap_det: 1'b0, wake: 1'b0,
        ack: 1'b0, rdata: '0
    };

    htc_state_t        s;
    htc_state_t        next_s;
    logic [SY_W-1:0]   sy;
    logic              req;
    logic              wr_take;
    logic              tick;
    logic              pin_clear;
    logic              cnt_load;
    logic              is_pwm;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   clr;
    logic [EV_W-1:0]   irq_mask;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    htc_sync #(
        .W (SY_W)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({register_bus_enable, timer_reset_in_n, timer_clock_in, capture_trigger_in}),
        .q   (sy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    assign req     = bus_req.read | bus_req.write;
    assign wr_take = bus_req.write & s.ack;
    assign is_pwm  = s.ctrl.mode[1];

    always_comb begin
        next_s    = s;
        tick      = 1'b0;
        ev        = '0;
        clr       = '0;
        pin_clear = 1'b0;
        cnt_load  = 1'b0;
        // one wait cycle, then the answer
        next_s.ack       = req & ~s.ack;
        next_s.prev_trig = sy[SY_TRIG];
        next_s.prev_tclk = sy[SY_TCLK];

        if (s.ctrl.enable && (!s.ctrl.clk_src || (sy[SY_TCLK] && !s.prev_tclk))) begin
            if (s.pre_cnt == s.prescale) begin
                next_s.pre_cnt = '0;
                tick           = 1'b1;
            end else begin
                next_s.pre_cnt = s.pre_cnt + 16'h0001;
            end
        end

        // compare against buffered value in PWM modes
        ev[EV_CMP] = tick && (s.cnt == (is_pwm ? s.cmp_sh : s.cmp));

        if (tick) begin
            unique case (s.ctrl.mode)
                HTC_WDOG: begin
                    // watchdog period restarts at reload value
                    if (s.cnt == (s.ctrl.down ? 16'h0000 : 16'hFFFF)) begin
                        next_s.cnt  = s.reload;
                        ev[EV_OVF]  = 1'b1;
                    end else begin
                        next_s.cnt = s.ctrl.down ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
                    end
                end
                HTC_CTC: begin
                    // cleared on match, or reloaded from compare when down
                    if (!s.ctrl.down && s.cnt == s.cmp) begin
                        next_s.cnt = '0;
                        ev[EV_OVF] = 1'b1;
                    end else if (s.ctrl.down && s.cnt == 16'h0000) begin
                        next_s.cnt = s.cmp;
                        ev[EV_OVF] = 1'b1;
                    end else begin
                        next_s.cnt = s.ctrl.down ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
                    end
                end
                HTC_FPWM: begin
                    if (s.cnt >= s.top_sh) begin
                        next_s.cnt = '0;
                        ev[EV_OVF] = 1'b1;
                    end else begin
                        next_s.cnt = s.cnt + 16'h0001;
                    end
                end
                HTC_PFC: begin
                    if (!s.going_down) begin
                        if (s.cnt >= s.top_sh) begin
                            next_s.going_down = 1'b1;
                            next_s.cnt        = (s.cnt == 16'h0000) ? 16'h0000 : s.cnt - 16'h0001;
                        end else begin
                            next_s.cnt = s.cnt + 16'h0001;
                        end
                    end else if (s.cnt == 16'h0000) begin
                        next_s.going_down = 1'b0;
                        next_s.cnt        = (s.top_sh == 16'h0000) ? 16'h0000 : 16'h0001;
                        ev[EV_OVF]        = 1'b1;
                    end else begin
                        next_s.cnt = s.cnt - 16'h0001;
                    end
                end
            endcase
        end

        // shadows load only at the period boundary, so a new period or duty
        // never cuts a pulse short; outside PWM they track freely
        if (!is_pwm || ev[EV_OVF]) begin
            next_s.top_sh = s.top;
            next_s.cmp_sh = s.cmp;
        end

        // capture one cycle after the edge is seen
        // only non-PWM modes with the bus attached
        next_s.cap_det = sy[SY_TRIG] && !s.prev_trig && s.ctrl.cap_en && !is_pwm && sy[SY_BUS];
        if (s.cap_det) begin
            next_s.cap  = s.cnt;
            ev[EV_CAP] = 1'b1;
        end

        // bus register writes
        if (wr_take) begin
            unique case (bus_req.address)
                OFF_CTRL:     next_s.ctrl     = htc_ctrl_t'(bus_req.writedata[CTRL_W-1:0]);
                OFF_PRESCALE: next_s.prescale = bus_req.writedata[CNT_W-1:0];
                OFF_TOP:      next_s.top      = bus_req.writedata[CNT_W-1:0];
                OFF_COMPARE:  next_s.cmp      = bus_req.writedata[CNT_W-1:0];
                OFF_RELOAD:   next_s.reload   = bus_req.writedata[CNT_W-1:0];
                OFF_CLEAR:    clr             = bus_req.writedata[EV_W-1:0];
                OFF_IRQEN:    next_s.irqen    = bus_req.writedata[EV_W-1:0];
                OFF_COUNT:    cnt_load        = 1'b1;
                default:      clr             = '0;
            endcase
        end
        if (cnt_load) begin
            next_s.cnt     = bus_req.writedata[CNT_W-1:0];
            next_s.pre_cnt = '0;
        end

        // pin reset clears the count, enabled by the preloaded bit
        // bit held set by preload keeps the pin live
        pin_clear = !sy[SY_RSTN] && s.ctrl.rst_pin_en;
        if (pin_clear) begin
            next_s.cnt        = '0;
            next_s.pre_cnt    = '0;
            next_s.going_down = 1'b0;
        end

        // output waveform: toggle on match, or duty from the shadow compare
        if (pin_clear) begin
            next_s.oc = 1'b0;
        end else if (is_pwm) begin
            next_s.oc = next_s.cnt < next_s.cmp_sh;
        end else if (ev[EV_CMP]) begin
            next_s.oc = ~s.oc;
        end

        // sticky events, a set beats a clear in the same cycle
        next_s.status = (s.status & ~clr) | ev;
        // wake pulse on any newly enabled event
        next_s.wake   = |(ev & irq_mask);

        // read data captured while waitrequest is high
        if (req && !s.ack && bus_req.read) begin
            unique case (bus_req.address)
                OFF_CTRL:     next_s.rdata = {25'h0000000, s.ctrl};
                OFF_PRESCALE: next_s.rdata = {16'h0000, s.prescale};
                OFF_TOP:      next_s.rdata = {16'h0000, s.top};
                OFF_COMPARE:  next_s.rdata = {16'h0000, s.cmp};
                OFF_COUNT:    next_s.rdata = {16'h0000, s.cnt};
                OFF_CAPTURE:  next_s.rdata = {16'h0000, s.cap};
                OFF_RELOAD:   next_s.rdata = {16'h0000, s.reload};
                OFF_STATUS:   next_s.rdata = {29'h00000000, s.status};
                OFF_IRQEN:    next_s.rdata = {29'h00000000, s.irqen};
                default:      next_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // with bus, enable register gates status
    assign irq_mask         = sy[SY_BUS] ? s.irqen : 3'h1;
    assign timer_irq_out    = |(s.status & irq_mask);
    assign wake_irq_out     = s.wake;
    assign compare_wave_out = s.oc;
    assign count_value      = s.cnt;
    assign readdata         = s.rdata;
    assign waitrequest      = req & ~s.ack;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_prescale;
        tick |-> s.ctrl.enable && (s.pre_cnt == s.prescale) ##1 (s.pre_cnt == 16'h0000 || pin_clear || $past(cnt_load));
    endproperty
    a_prescale: assert property (p_prescale) else $error("tick without prescale terminal count");

    property p_fpwm_wrap;
        (tick && s.ctrl.mode == HTC_FPWM && s.cnt >= s.top_sh && !cnt_load && !pin_clear)
            |=> (s.cnt == 16'h0000) && s.status[EV_OVF];
    endproperty
    a_fpwm_wrap: assert property (p_fpwm_wrap) else $error("fast pwm did not wrap to zero");

    property p_capture;
        s.cap_det |=> (s.cap == $past(s.cnt)) && s.status[EV_CAP];
    endproperty
    a_capture: assert property (p_capture) else $error("capture value or flag wrong");

    property p_cap_gate;
        s.cap_det |-> $past(!is_pwm && sy[SY_BUS] && s.ctrl.cap_en);
    endproperty
    a_cap_gate: assert property (p_cap_gate) else $error("capture in a forbidden mode");

    property p_sync_edge;
        $rose(sy[SY_TRIG]) && s.ctrl.cap_en && !is_pwm && sy[SY_BUS] |=> s.cap_det ##1 s.status[EV_CAP];
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("synchronised edge not captured");

    property p_standalone_irq;
        !sy[SY_BUS] |-> (timer_irq_out == s.status[EV_OVF]);
    endproperty
    a_standalone_irq: assert property (p_standalone_irq) else $error("irq is not overflow flag");

    property p_bus_irq;
        sy[SY_BUS] && ((s.status & s.irqen) == 3'h0) |-> !timer_irq_out;
    endproperty
    a_bus_irq: assert property (p_bus_irq) else $error("irq raised with nothing enabled");

    property p_wake;
        ev[EV_OVF] && irq_mask[EV_OVF] |=> wake_irq_out && s.status[EV_OVF];
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse on overflow");

    property p_pin_reset;
        !sy[SY_RSTN] && s.ctrl.rst_pin_en |=> (s.cnt == 16'h0000) && !compare_wave_out;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset did not clear count");

    property p_shadow;
        is_pwm && !ev[EV_OVF] |=> $stable(s.cmp_sh) && $stable(s.top_sh);
    endproperty
    a_shadow: assert property (p_shadow) else $error("pwm shadow changed mid period");

endmodule

// ### include/htc_pkg.sv
// Behaviour
// - 16-bit up/down counter feeds compare and PWM
// - modes: watchdog, clear-on-compare, fast PWM, phase-correct PWM
// - selectable clock source with programmable prescaler
// - enabled capture copies count on synchronized rising edge
// - capture only in non-PWM modes with bus
// - interrupt sources: overflow, compare match, capture
// - with bus, interrupt gated by the enable register
// - without bus, interrupt output is overflow flag
// - stand-alone: preloaded controls, counter reset by pin
// - reset-pin enable bit preloaded, keeps pin active
// - glitch-free PWM with variable period
// - separate wake-up interrupt to standby controller
package htc_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int EV_W   = 3;

    localparam logic [ADDR_W-1:0] OFF_CTRL     = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_TOP      = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_COMPARE  = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE  = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_RELOAD   = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_CLEAR    = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_IRQEN    = 6'h24;

    // event bit positions in status, clear and enable
    localparam int EV_OVF = 0;
    localparam int EV_CMP = 1;
    localparam int EV_CAP = 2;

    // synchronised pin vector positions
    localparam int SY_TRIG = 0;
    localparam int SY_TCLK = 1;
    localparam int SY_RSTN = 2;
    localparam int SY_BUS  = 3;
    localparam int SY_W    = 4;

    typedef enum logic [1:0] {
        HTC_WDOG = 2'b00,
        HTC_CTC  = 2'b01,
        HTC_FPWM = 2'b10,
        HTC_PFC  = 2'b11
    } htc_mode_t;

    // control register, bit 0 upward: mode[1:0], down, enable, cap_en, clk_src, rst_pin_en
    typedef struct packed {
        logic      rst_pin_en;
        logic      clk_src;
        logic      cap_en;
        logic      enable;
        logic      down;
        htc_mode_t mode;
    } htc_ctrl_t;

    localparam int CTRL_W = 7;

    localparam htc_ctrl_t        CTRL_RST     = 7'h50;
    localparam logic [CNT_W-1:0] PRESCALE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] TOP_RST      = 16'hFFFF;
    localparam logic [CNT_W-1:0] COMPARE_RST  = 16'hFFFF;
    localparam logic [CNT_W-1:0] RELOAD_RST   = 16'h0000;
    localparam logic [EV_W-1:0]  IRQEN_RST    = 3'h0;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } htc_avs_req_t;

endpackage

// ### verilog/htc_sync.sv
`timescale 1ns/1ps
module htc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ### dv/htc_bus_model.sv
`timescale 1ns/1ps
module htc_bus_model (
    input  wire logic                  clk,
    input  wire logic [31:0]           readdata,
    input  wire logic                  waitrequest,
    output htc_pkg::htc_avs_req_t      bus_req
);
    import htc_pkg::*;

    initial bus_req = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // released address and data lines carry inverted values so stale data is never mistaken for live
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q = '0;
        @(posedge clk);
        bus_req <= '{read: ~w, write: w, address: a, writedata: d};
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) begin
                ok = 1'b1;
                q = readdata;
            end
        end
        bus_req <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d};
    endtask
endmodule

// ### dv/htc_timer_tb_top.sv
`timescale 1ns/1ps
module htc_timer_tb_top;
    import htc_pkg::*;
    logic               clk, rst, bus_en, tclk_in, trst_n, trig, wave, irq, wake, ok, waitrequest, prev, dn;
    htc_avs_req_t       bus_req;
    logic [DATA_W-1:0]  readdata, rd, seed;
    logic [CNT_W-1:0]   count, n0, v, t, mx;
    int                 errors, compares, k, m, hi, tg, e;
    logic [5:0]         offs [8] = '{OFF_CTRL, OFF_PRESCALE, OFF_TOP, OFF_COMPARE, OFF_RELOAD,
                                     OFF_IRQEN, OFF_STATUS, 6'h28};
    logic [31:0]        exps [8] = '{32'h50, 0, 32'hFFFF, 32'hFFFF, 0, 0, 0, 0};

    always #5 clk = ~clk;
    // external count source at clk/8
    always begin
        repeat (4) @(posedge clk);
        tclk_in <= ~tclk_in;
    end

    htc_timer u_htc_timer (.clk(clk), .rst(rst), .bus_req(bus_req), .readdata(readdata),
        .waitrequest(waitrequest), .register_bus_enable(bus_en), .timer_clock_in(tclk_in),
        .timer_reset_in_n(trst_n), .capture_trigger_in(trig), .compare_wave_out(wave),
        .count_value(count), .timer_irq_out(irq), .wake_irq_out(wake));
    htc_bus_model u_htc_bus_model (.clk(clk), .readdata(readdata), .waitrequest(waitrequest),
        .bus_req(bus_req));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] ctl(input int md, input logic dwn, en, cap, src);
        htc_ctrl_t c;
        c = '{rst_pin_en: 1'b1, clk_src: src, cap_en: cap, enable: en, down: dwn, mode: htc_mode_t'(md)};
        return {25'h0, c};
    endfunction

    function automatic int ticks(input int src, input int p, input int c);
        return (src != 0) ? c / 8 : c / (p + 1);
    endfunction

    task automatic close_out();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        u_htc_bus_model.xfer(w, a, d, rd, ok);
        if (ok !== 1'b1) begin
            errors++;
            close_out();
        end
    endtask

    // stop the counter and load a known setup while shadows follow continuously
    task automatic setup(input logic [15:0] p, input logic [15:0] c0);
        acc(1'b1, OFF_CTRL, ctl(0, 1'b0, 1'b0, 1'b0, 1'b0));
        acc(1'b1, OFF_PRESCALE, {16'h0, p});
        acc(1'b1, OFF_COUNT, {16'h0, c0});
        acc(1'b1, OFF_CLEAR, 32'h7);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0; rst = 1; bus_en = 1; tclk_in = 0; trst_n = 1; trig = 0;
        errors = 0; compares = 0; seed = 32'h0000002E;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (k = 0; k < 8; k++) begin
            acc(1'b0, offs[k], 32'h0);
            check(rd, exps[k]);
        end
        acc(1'b1, OFF_STATUS, 32'h7);
        acc(1'b0, OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        for (k = 0; k < 4; k++) begin
            acc(1'b1, OFF_CTRL, ctl(k, k[0], 1'b0, 1'b0, 1'b0));
            acc(1'b0, OFF_CTRL, 32'h0);
            check(rd, ctl(k, k[0], 1'b0, 1'b0, 1'b0));
        end
        $display("test reset_and_modes done");

        seed = xs(seed);
        v = {1'b0, seed[14:0]};
        setup(16'h00FF, 16'hFFFF);
        acc(1'b1, OFF_RELOAD, {16'h0, v});
        acc(1'b1, OFF_CTRL, ctl(0, 1'b0, 1'b1, 1'b0, 1'b0));
        for (k = 0; k < 200; k++) begin
            acc(1'b0, OFF_STATUS, 32'h0);
            if (rd[EV_OVF] === 1'b1) break;
        end
        check(rd[EV_OVF], 1);
        check(count, v);
        check(irq, 0);
        acc(1'b1, OFF_IRQEN, 32'h1);
        @(posedge clk);
        check(irq, 1);
        acc(1'b1, OFF_CLEAR, 32'h7);
        @(posedge clk);
        check(irq, 0);
        $display("test overflow_reload_irq done");

        for (m = 0; m < 3; m++) begin
            setup(m == 1 ? 16'h1 : 16'h0, 16'h8000);
            acc(1'b1, OFF_CTRL, ctl(0, 1'b1, 1'b1, 1'b0, m == 2));
            @(posedge clk);
            n0 = count;
            repeat (80) @(posedge clk);
            e = ticks(m == 2, m == 1, 80);
            k = int'(n0) - int'(count);
            check(k >= e - 1 && k <= e + 1, 1);
        end
        $display("test direction_and_source done");

        seed = xs(seed);
        v = 16'h10 + seed[5:0];
        setup(16'h0, 16'h0);
        acc(1'b1, OFF_COMPARE, {16'h0, v});
        acc(1'b1, OFF_CTRL, ctl(1, 1'b0, 1'b1, 1'b0, 1'b0));
        mx = 0;
        tg = 0;
        prev = wave;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if (count > mx) mx = count;
            if (wave !== prev) tg++;
            prev = wave;
        end
        check(mx, v);
        e = 300 / (v + 1);
        check(tg >= e - 1 && tg <= e + 1, 1);
        acc(1'b0, OFF_STATUS, 32'h0);
        check(rd[1:0], 2'b11);
        // counting down from 3 reaches zero on the third tick and loads compare on the fourth
        setup(16'h0, 16'h0003);
        acc(1'b1, OFF_CTRL, ctl(1, 1'b1, 1'b1, 1'b0, 1'b0));
        repeat (5) @(posedge clk);
        check(count, v);
        $display("test clear_on_compare done");

        for (m = 2; m < 4; m++) begin
            seed = xs(seed);
            t = 16'h8 + seed[4:0];
            setup(16'h0, 16'h0);
            acc(1'b1, OFF_TOP, {16'h0, t});
            acc(1'b1, OFF_COMPARE, {17'h0, t[15:1]});
            acc(1'b1, OFF_CTRL, ctl(m, 1'b0, 1'b1, 1'b0, 1'b0));
            repeat (4 * (t + 1)) @(posedge clk);
            mx = 0;
            hi = 0;
            dn = 0;
            n0 = count;
            for (k = 0; k < 4 * (t + 1); k++) begin
                @(posedge clk);
                if (count > mx) mx = count;
                if (count == n0 - 16'h1) dn = 1;
                n0 = count;
                hi += (wave === 1'b0) ? 0 : 1;
            end
            check(mx, t);
            check(dn, m == 3);
            if (m == 2) check(hi, 4 * t[15:1]);
        end
        $display("test pwm done");

        for (m = 0; m < 3; m += 2) begin
            seed = xs(seed);
            v = seed[15:0];
            setup(16'h00FF, v);
            acc(1'b1, OFF_IRQEN, 32'h4);
            acc(1'b1, OFF_CTRL, ctl(m, 1'b0, 1'b1, 1'b1, 1'b0));
            trig <= 1'b1;
            tg = 0;
            for (k = 0; k < 12; k++) begin
                @(posedge clk);
                // pin to flag takes two sync flops, one detect cycle and one capture cycle
                if (k == 3) check(irq, 0);
                if (k == 4) check(irq, m == 0);
                tg += (wake === 1'b0) ? 0 : 1;
            end
            trig <= 1'b0;
            check(tg, m == 0);
            acc(1'b0, OFF_STATUS, 32'h0);
            check(rd[EV_CAP], m == 0);
            acc(1'b0, OFF_CAPTURE, 32'h0);
            if (m == 0) check(rd, {16'h0, v});
        end
        $display("test capture done");

        setup(16'h0, 16'hFFF0);
        acc(1'b1, OFF_IRQEN, 32'h0);
        acc(1'b1, OFF_CTRL, ctl(0, 1'b0, 1'b1, 1'b0, 1'b0));
        bus_en <= 1'b0;
        repeat (40) @(posedge clk);
        check(irq, 1);
        trst_n <= 1'b0;
        repeat (6) @(posedge clk);
        check(count, 0);
        repeat (20) @(posedge clk);
        check(count, 0);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check(count != 0, 1);
        $display("test stand_alone done");
        close_out();
    end
endmodule
